//--- hdl/avg_consts.svh
/*
  Named constants for the scan oversampling averager: register offsets,
  field positions, reset values and timing figures.
  Assumes inclusion by bare name from the design files.
*/
`ifndef AVG_CONSTS_SVH
`define AVG_CONSTS_SVH

`define REG_CTRL       8'h00
`define REG_OS_COUNT   8'h04
`define REG_CONV_PER   8'h08
`define REG_SCAN_LEN   8'h0C
`define REG_SCAN_SEL   8'h10
`define REG_SCAN_DATA  8'h14
`define REG_STATUS     8'h18
`define REG_RESULT     8'h1C

`define CTRL_GO        0
`define CTRL_OS_EN     1
`define CTRL_LCR_EN    2
`define CTRL_MAINS60   3
`define CTRL_LOG2_LO   4
`define CTRL_LOG2_HI   7

`define STAT_BUSY      0
`define STAT_DONE      1
`define STAT_IDX_LO    8

`define ENT_CHAN_LO    0
`define ENT_CHAN_HI    7
`define ENT_GAIN_LO    8
`define ENT_GAIN_HI    10
`define ENT_DIGITAL    11

`define OS_MIN         15'h0002
`define OS_MAX         15'h4000
`define OS_RESET       15'h0002
`define PER_RESET      16'h0040
`define LOG2_RESET     4'hE
`define LOG2_MAX       4'hE

`define CLK_NS         5
`define MAINS50_NS     20000000
`define MAINS60_NS     16666000

`endif

//--- hdl/avg_pkg.sv
/*
  Types shared by the averager files.
  Assumes avg_consts.svh is compiled alongside.
*/
package avg_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_ISSUE,
    ST_WAIT,
    ST_FINISH
  } scan_state_e;

  typedef struct packed {
    logic       digital;
    logic [2:0] gain;
    logic [7:0] chan;
  } entry_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  index;
    logic [15:0] data;
  } result_s;

endpackage : avg_pkg

//--- hdl/scan_accum.sv
/*
  Accumulates samples of one scan entry and divides the sum by the
  sample count with a serial restoring divider.
  A finish may come with the last add, and the divide then includes that
  sample; assumes no add arrives while the divide runs.
*/
`timescale 1ns/10ps
module scan_accum #(
  parameter int ACC_W = 30,
  parameter int CNT_W = 15
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Sample input
  input  wire logic             add_en,
  input  wire logic [15:0]      sample,
  // Result control
  input  wire logic             finish,
  input  wire logic [CNT_W-1:0] count,
  output logic                  done,
  output logic [15:0]           avg
);
  localparam int BW = $clog2(ACC_W + 1);

  logic [ACC_W-1:0] sum_r;
  logic [CNT_W:0]   rem_r;
  logic [BW-1:0]    step_r;
  logic             busy_r;
  logic [CNT_W:0]   rem_sh;
  logic             qbit;

  initial begin
    if (ACC_W < 30 || CNT_W < 15)
      $error("scan_accum: sum or count too narrow");  // [RQ9]
  end

  assign rem_sh = {rem_r[CNT_W-1:0], sum_r[ACC_W-1]};
  assign qbit   = (rem_sh >= {1'b0, count});

  // Sum, then divide in place; quotient shifts into the sum register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sum_r  <= '0;
      rem_r  <= '0;
      step_r <= '0;
      busy_r <= 1'b0;
      done   <= 1'b0;
      avg    <= '0;
    end else begin
      done <= 1'b0;
      if (add_en && !busy_r) begin
        sum_r <= sum_r + ACC_W'(sample);  // [RQ6]
        if (finish) begin
          busy_r <= 1'b1;  // [RQ10]
          rem_r  <= '0;
          step_r <= '0;
        end
      end else if (finish && !busy_r) begin
        busy_r <= 1'b1;
        rem_r  <= '0;
        step_r <= '0;
      end else if (busy_r) begin
        rem_r <= qbit ? rem_sh - {1'b0, count} : rem_sh;
        if (step_r == BW'(ACC_W - 1)) begin
          avg    <= {sum_r[14:0], qbit};  // [RQ9]
          sum_r  <= '0;  // [RQ10]
          busy_r <= 1'b0;
          done   <= 1'b1;
        end else begin
          sum_r  <= {sum_r[ACC_W-2:0], qbit};
          step_r <= step_r + 1'b1;
        end
      end
    end
  end

  chk_acc_grow: assert property (@(posedge clk) disable iff (rst)  // [RQ6]
    add_en && !busy_r |=> sum_r == $past(sum_r) + ACC_W'($past(sample)))
    else $error("sum did not grow by the sample");
  chk_acc_clear: assert property (@(posedge clk) disable iff (rst)  // [RQ10]
    done |-> sum_r == '0 && !busy_r)
    else $error("sum not cleared with the result");
  chk_div_len: assert property (@(posedge clk) disable iff (rst)  // [RQ9]
    $rose(busy_r) |-> ##30 done)
    else $error("divide did not take the sum width in cycles");

endmodule : scan_accum

//--- hdl/scan_oversampling_averager.sv
/*
  Scan engine stage that converts each scan entry one or many times,
  averages the 16-bit codes and emits one result per entry.
  Assumes the converter holds adc_data steady while adc_done is high and
  that the register port master follows the one-cycle strobe protocol.
*/
// Function
// RQ1: With oversampling on, the count per entry is settable from 2 to 16384.
// RQ2: The count applies to every analog entry of the scan list alike.
// RQ3: A digital entry is always read exactly once.
// RQ4: With oversampling off, each entry is converted once, in list order.
// RQ5: Oversampled conversions of an entry keep its channel and gain fixed.
// RQ6: All conversions of an entry are averaged into its single result.
// RQ7: Line-cycle mode averages a power-of-two count over one mains cycle.
// RQ8: Line-cycle mode stretches the period so the count fills 20/16.666 ms.
// RQ9: The sum is at least 30 bits and is divided by the count.
// RQ10: The result is valid only after the last sample, then the sum clears.
`timescale 1ns/10ps
`include "avg_consts.svh"
module scan_oversampling_averager #(
  parameter int DEPTH       = 16,
  parameter int MAINS50_CYC = `MAINS50_NS / `CLK_NS,
  parameter int MAINS60_CYC = `MAINS60_NS / `CLK_NS
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // Register port
  input  wire logic [7:0]     addr,
  input  wire logic [31:0]    wdata,
  input  wire logic           wr,
  input  wire logic           rd,
  output logic      [31:0]    rdata,
  // Converter and multiplexer
  output logic                adc_start,
  output logic      [7:0]     adc_chan,
  output logic      [2:0]     adc_gain,
  output logic                adc_digital,
  input  wire logic           adc_done,
  input  wire logic [15:0]    adc_data,
  // Result stream
  output avg_pkg::result_s    res
);
  import avg_pkg::*;

  localparam int IW = $clog2(DEPTH);
  localparam int TW = 23;

  initial begin
    if (DEPTH < 2 || DEPTH > 256 || MAINS50_CYC >= (1 << TW) ||
        MAINS60_CYC >= (1 << TW) || MAINS60_CYC < 16384)
      $error("scan_oversampling_averager: unsupported parameters");
  end

  function automatic logic [14:0] pow2(input logic [3:0] k);
    pow2 = 15'(1) << k;
  endfunction : pow2

  scan_state_e      state_r;
  entry_s           list_r [DEPTH];
  entry_s           cur;
  logic             os_en_r, lcr_en_r, mains60_r, done_r;
  logic [3:0]       log2_r;
  logic [14:0]      os_count_r, target_r, n_r, frac_r;
  logic [15:0]      per_r, last_r;
  logic [IW:0]      len_r, idx_r;
  logic [IW-1:0]    sel_r;
  logic [TW-1:0]    timer_r, mains, base, frac_add;
  logic [15:0]      frac_sum;
  logic             carry, go, tick;
  logic             done_s1, done_s2, done_s3, sample_evt;
  logic [15:0]      data_s1, data_s2;
  logic             acc_done;
  logic [15:0]      acc_avg;
  logic [14:0]      wcount;

  assign cur    = list_r[idx_r[IW-1:0]];
  assign go     = wr && addr == `REG_CTRL && wdata[`CTRL_GO];
  assign wcount = wdata[14:0];

  // Mains cycle split into equal periods; the remainder is spread so the
  // whole count lands exactly on one cycle.
  assign mains    = mains60_r ? TW'(MAINS60_CYC) : TW'(MAINS50_CYC);
  assign base     = mains >> log2_r;  // [RQ8]
  assign frac_add = mains & TW'(pow2(log2_r) - 15'(1));
  assign frac_sum = {1'b0, frac_r} + 16'(frac_add);
  assign carry    = frac_sum >= {1'b0, pow2(log2_r)};
  assign tick     = timer_r == '0;

  // Converter answers come from outside the clock domain.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      data_s1 <= '0;
      data_s2 <= '0;
    end else begin
      done_s1 <= adc_done;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      data_s1 <= adc_data;
      data_s2 <= data_s1;
    end
  end
  assign sample_evt = done_s2 && !done_s3 && state_r == ST_WAIT;

  // Configuration registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      os_en_r    <= 1'b0;
      lcr_en_r   <= 1'b0;
      mains60_r  <= 1'b0;
      log2_r     <= `LOG2_RESET;
      os_count_r <= `OS_RESET;
      per_r      <= `PER_RESET;
      len_r      <= '0;
      sel_r      <= '0;
    end else if (wr && state_r == ST_IDLE) begin
      case (addr)
        `REG_CTRL: begin
          os_en_r   <= wdata[`CTRL_OS_EN];
          lcr_en_r  <= wdata[`CTRL_LCR_EN];
          mains60_r <= wdata[`CTRL_MAINS60];
          log2_r    <= (wdata[`CTRL_LOG2_HI:`CTRL_LOG2_LO] > `LOG2_MAX) ?
                       `LOG2_MAX : wdata[`CTRL_LOG2_HI:`CTRL_LOG2_LO];
        end
        `REG_OS_COUNT: begin
          if (wdata[31:15] != '0 || wcount > `OS_MAX)
            os_count_r <= `OS_MAX;  // [RQ1]
          else if (wcount < `OS_MIN)
            os_count_r <= `OS_MIN;  // [RQ1]
          else
            os_count_r <= wcount;  // [RQ1]
        end
        `REG_CONV_PER: per_r <= (wdata[15:0] == '0) ? 16'h0001 : wdata[15:0];
        `REG_SCAN_LEN: len_r <= (wdata[IW:0] > (IW+1)'(DEPTH)) ?
                                (IW+1)'(DEPTH) : wdata[IW:0];
        `REG_SCAN_SEL: sel_r <= wdata[IW-1:0];
        default: ;
      endcase
    end
  end

  // Scan list storage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++)
        list_r[i] <= '0;
    end else if (wr && addr == `REG_SCAN_DATA && state_r == ST_IDLE) begin
      list_r[sel_r] <= entry_s'(wdata[`ENT_DIGITAL:`ENT_CHAN_LO]);
    end
  end

  // Sequencer.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      idx_r       <= '0;
      n_r         <= '0;
      target_r    <= 15'h0001;
      timer_r     <= '0;
      frac_r      <= '0;
      adc_start   <= 1'b0;
      adc_chan    <= '0;
      adc_gain    <= '0;
      adc_digital <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      if (!tick)
        timer_r <= timer_r - 1'b1;
      case (state_r)
        ST_IDLE: begin
          if (go && len_r != '0) begin
            idx_r   <= '0;
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          adc_chan    <= cur.chan;  // [RQ4] [RQ5]
          adc_gain    <= cur.gain;  // [RQ4] [RQ5]
          adc_digital <= cur.digital;
          n_r         <= '0;
          frac_r      <= '0;
          if (cur.digital || !os_en_r)
            target_r <= 15'h0001;  // [RQ3] [RQ4]
          else if (lcr_en_r)
            target_r <= pow2(log2_r);  // [RQ7]
          else
            target_r <= os_count_r;  // [RQ2]
          state_r <= ST_ISSUE;
        end
        ST_ISSUE: begin
          if (tick) begin
            adc_start <= 1'b1;
            if (os_en_r && lcr_en_r && !adc_digital) begin
              frac_r  <= carry ? 15'(frac_sum - {1'b0, pow2(log2_r)}) :
                                 frac_sum[14:0];
              timer_r <= carry ? base : base - 1'b1;  // [RQ8]
            end else begin
              timer_r <= TW'(per_r - 16'h0001);
            end
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (sample_evt) begin
            n_r     <= n_r + 1'b1;
            state_r <= (n_r + 1'b1 == target_r) ? ST_FINISH : ST_ISSUE;  // [RQ5]
          end
        end
        ST_FINISH: begin
          if (acc_done) begin
            idx_r   <= idx_r + 1'b1;  // [RQ4]
            state_r <= (idx_r + 1'b1 == len_r) ? ST_IDLE : ST_LOAD;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  scan_accum #(
    .ACC_W (30),
    .CNT_W (15)
  ) u_accum (
    .clk    (clk),
    .rst    (rst),
    .add_en (sample_evt),  // [RQ6]
    .sample (data_s2),
    .finish (state_r == ST_WAIT && sample_evt && n_r + 1'b1 == target_r),
    .count  (target_r),
    .done   (acc_done),
    .avg    (acc_avg)
  );

  // Result stream, last result and the sticky scan-done flag.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res    <= '0;
      last_r <= '0;
      done_r <= 1'b0;
    end else begin
      res.valid <= acc_done;  // [RQ10]
      if (acc_done) begin
        res.data  <= acc_avg;
        res.index <= 8'(idx_r);
        last_r    <= acc_avg;
      end
      if (acc_done && idx_r + 1'b1 == len_r)
        done_r <= 1'b1;
      else if (wr && addr == `REG_STATUS && wdata[`STAT_DONE])
        done_r <= 1'b0;
    end
  end

  // Read port: data one cycle after the strobe, zero otherwise.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= '0;
      if (rd) begin
        case (addr)
          `REG_CTRL: rdata <= {24'h000000, log2_r, mains60_r, lcr_en_r,
                               os_en_r, 1'b0};
          `REG_OS_COUNT:  rdata <= {17'h00000, os_count_r};
          `REG_CONV_PER:  rdata <= {16'h0000, per_r};
          `REG_SCAN_LEN:  rdata <= 32'(len_r);
          `REG_SCAN_SEL:  rdata <= 32'(sel_r);
          `REG_SCAN_DATA: rdata <= 32'(list_r[sel_r]);
          `REG_STATUS:    rdata <= {16'h0000, 8'(idx_r), 6'h00, done_r,
                                    state_r != ST_IDLE};
          `REG_RESULT:    rdata <= {16'h0000, last_r};
          default:        rdata <= '0;
        endcase
      end
    end
  end

  chk_count_range: assert property (@(posedge clk) disable iff (rst)  // [RQ1]
    os_count_r >= `OS_MIN && os_count_r <= `OS_MAX)
    else $error("oversample count out of range");
  chk_analog_count: assert property (@(posedge clk) disable iff (rst)  // [RQ2]
    state_r == ST_LOAD && !cur.digital && os_en_r && !lcr_en_r
    |=> target_r == $past(os_count_r))
    else $error("analog entry did not take the count");
  chk_digital_once: assert property (@(posedge clk) disable iff (rst)  // [RQ3]
    state_r == ST_LOAD && cur.digital |=> target_r == 15'h0001)
    else $error("digital entry read more than once");
  chk_off_single: assert property (@(posedge clk) disable iff (rst)  // [RQ4]
    state_r == ST_LOAD && !os_en_r |=> target_r == 15'h0001 &&
    adc_chan == $past(cur.chan) && adc_gain == $past(cur.gain))
    else $error("single conversion entry set up wrongly");
  chk_chan_hold: assert property (@(posedge clk) disable iff (rst)  // [RQ5]
    state_r inside {ST_ISSUE, ST_WAIT} && $past(state_r) != ST_LOAD
    |-> $stable(adc_chan) && $stable(adc_gain))
    else $error("channel or gain moved within an entry");
  chk_lcr_count: assert property (@(posedge clk) disable iff (rst)  // [RQ7]
    state_r == ST_LOAD && !cur.digital && os_en_r && lcr_en_r
    |=> target_r == pow2(log2_r))
    else $error("line-cycle count is not the power of two");
  chk_lcr_period: assert property (@(posedge clk) disable iff (rst)  // [RQ8]
    adc_start && os_en_r && lcr_en_r && !adc_digital
    |-> timer_r == base || timer_r == base - 1'b1)
    else $error("line-cycle period not stretched to the mains share");
  chk_res_last: assert property (@(posedge clk) disable iff (rst)  // [RQ10]
    res.valid |-> n_r == target_r && $past(state_r) == ST_FINISH)
    else $error("result before the last conversion");

endmodule : scan_oversampling_averager

//--- verification/adc_model.sv
/*
  Behavioural converter and input multiplexer for the averager bench.
  Assumes the averager pulses adc_start once per conversion and holds
  channel and gain for the whole entry; each code is a function of the
  channel, the gain and the sample parity within the entry.
*/
`timescale 1ns/10ps
module adc_model (
  // Clock
  input  wire logic        clk,
  // Conversion control
  input  wire logic        adc_start,
  input  wire logic [7:0]  adc_chan,
  input  wire logic [2:0]  adc_gain,
  input  wire logic        slow,
  // Conversion result
  output logic             adc_done,
  output logic [15:0]      adc_data
);
  int          asked  = 0;
  int          served = 0;
  logic        odd    = 1'b0;
  logic [10:0] last   = 11'h000;

  always @(posedge clk) begin
    if (adc_start === 1'b1) asked <= asked + 1;
  end

  // Data is inverted once its hold time ends, so a late sample shows.
  initial begin
    adc_done = 1'b0;
    adc_data = 16'h5A5A;
    forever begin
      @(posedge clk);
      if (served < asked) begin
        served++;
        if ({adc_gain, adc_chan} !== last) odd = 1'b0;
        last = {adc_gain, adc_chan};
        repeat (slow ? 20 : 2) @(posedge clk);
        adc_data <= {adc_chan, 5'h00, adc_gain} + (odd ? 16'h0020 : 16'h0000);
        repeat (4) @(posedge clk);
        adc_done <= 1'b1;
        repeat (2) @(posedge clk);
        adc_done <= 1'b0;
        repeat (3) @(posedge clk);
        adc_data <= ~adc_data;
        odd = ~odd;
      end
    end
  end
endmodule : adc_model

//--- verification/scan_oversampling_averager_tb.sv
/*
  Self-checking bench for the scan oversampling averager.
  Assumes the register map of avg_consts.svh and the converter model
  adc_model; mains periods are shortened through the parameters.
*/
`timescale 1ns/10ps
`include "avg_consts.svh"
module scan_oversampling_averager_tb;
  import avg_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, slow = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic        adc_start, adc_digital, adc_done;
  logic [7:0]  adc_chan;
  logic [2:0]  adc_gain;
  logic [15:0] adc_data;
  result_s     res;
  int          failures = 0, compares = 0, nres = 0, cyc = 0;
  int          gap = 0, last_gap = 0;
  int          starts [256];
  logic        dig [256];
  logic [7:0]  rix [16];
  logic [15:0] rdat [16];
  logic [11:0] ent [3] = '{12'h103, 12'hA05, 12'h407};

  always #2.5 clk = ~clk;

  scan_oversampling_averager #(.DEPTH(16), .MAINS50_CYC(16384),
    .MAINS60_CYC(16400)) u_scan_oversampling_averager (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .adc_start(adc_start), .adc_chan(adc_chan),
    .adc_gain(adc_gain), .adc_digital(adc_digital), .adc_done(adc_done),
    .adc_data(adc_data), .res(res));

  adc_model u_adc_model (.clk(clk), .adc_start(adc_start),
    .adc_chan(adc_chan), .adc_gain(adc_gain), .slow(slow),
    .adc_done(adc_done), .adc_data(adc_data));

  always @(posedge clk) begin
    cyc <= cyc + 1;
    gap <= gap + 1;
    if (adc_start === 1'b1) begin
      starts[adc_chan] <= starts[adc_chan] + 1;
      dig[adc_chan] <= adc_digital;
      last_gap <= gap + 1;
      gap <= 0;
    end
    if (res.valid === 1'b1) begin
      rix[nres % 16] <= res.index;
      rdat[nres % 16] <= res.data;
      nres <= nres + 1;
    end
    if (cyc == 90000) begin
      failures++;
      close_out();
    end
  end

  task close_out;
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  task run_scan(input logic [31:0] ctrl, input int n);
    int k;
    nres = 0;
    for (int i = 0; i < 256; i++) starts[i] = 0;
    wr_reg(`REG_CTRL, ctrl);
    k = 0;
    while (nres < n && k < 40000) begin
      @(posedge clk);
      k++;
    end
    check(nres, n);
    repeat (4) @(posedge clk);
  endtask : run_scan

  task check_res(input int i, input logic [15:0] d, input int nconv);
    check(rix[i], i);
    check(rdat[i], d);
    check(starts[ent[i][7:0]], nconv);
    check(dig[ent[i][7:0]], ent[i][11]);
  endtask : check_res

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`REG_OS_COUNT);
    check(v, 32'h2);
    rd_reg(`REG_CONV_PER);
    check(v, 32'h40);
    @(posedge clk);
    #1 check(rdata, 32'h0);
    rd_reg(8'h20);
    check(v, 32'h0);
    wr_reg(`REG_OS_COUNT, 32'h1);
    rd_reg(`REG_OS_COUNT);
    check(v, 32'h2);
    wr_reg(`REG_OS_COUNT, 32'h7FFF);
    rd_reg(`REG_OS_COUNT);
    check(v, 32'h4000);
    for (int i = 0; i < 3; i++) begin
      wr_reg(`REG_SCAN_SEL, i);
      wr_reg(`REG_SCAN_DATA, {20'h0, ent[i]});
    end
    wr_reg(`REG_SCAN_LEN, 32'h3);
    wr_reg(`REG_CONV_PER, 32'h8);
    run_scan(32'h1, 3);
    check_res(0, 16'h0301, 1);
    check_res(1, 16'h0502, 1);
    check_res(2, 16'h0704, 1);
    rd_reg(`REG_STATUS);
    check(v[1:0], 2'b10);
    rd_reg(`REG_RESULT);
    check(v[15:0], 16'h0704);
    wr_reg(`REG_STATUS, 32'h2);
    rd_reg(`REG_STATUS);
    check(v[1:0], 2'b00);
    $display("test single conversions ended");
    wr_reg(`REG_OS_COUNT, 32'h4);
    run_scan(32'h3, 3);
    check_res(0, 16'h0311, 4);
    check_res(1, 16'h0502, 1);
    check_res(2, 16'h0714, 4);
    $display("test oversampling by four ended");
    slow <= 1'b1;
    wr_reg(`REG_OS_COUNT, 32'h2);
    run_scan(32'h3, 3);
    check_res(0, 16'h0311, 2);
    check_res(1, 16'h0502, 1);
    check_res(2, 16'h0714, 2);
    slow <= 1'b0;
    $display("test minimum count ended");
    wr_reg(`REG_SCAN_LEN, 32'h1);
    run_scan(32'h17, 1);
    check(last_gap, 16384 >> 1);
    check_res(0, 16'h0311, 2);
    run_scan(32'h1F, 1);
    check(last_gap, 16400 >> 1);
    check_res(0, 16'h0311, 2);
    $display("test line cycle ended");
    close_out();
  end
endmodule : scan_oversampling_averager_tb
